/* rtl/csf_alu_if.sv */
// Operand and flag bundle between the flag core and the flag calculator
`timescale 1ns/1ps
interface csf_alu_if;
	import csf_pkg::*;
	csf_op_e op;
	logic [7:0] a;
	logic [7:0] b;
	logic cin;
	logic [7:0] res;
	logic cout;
	logic nib_cout;
	logic msb_cin;
	modport calc(input op, input a, input b, input cin,
		output res, output cout, output nib_cout, output msb_cin);
	modport core(output op, output a, output b, output cin,
		input res, input cout, input nib_cout, input msb_cin);
endinterface

/* rtl/csf_core.sv */
// Status flags, table pointers and table read sequencer of the CPU core
`timescale 1ns/1ps
module csf_core
	import csf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic instr_vld_i,
	input wire csf_op_e instr_op_i,
	input wire logic [7:0] op_a_i,
	input wire logic [7:0] op_b_i,
	input wire logic [7:0] tbl_dst_i,
	input wire logic wdt_expire_i,
	output logic [7:0] flags_o,
	output logic [7:0] result_o,
	output logic result_vld_o,
	output logic [PMEM_DW-1:0] pmem_addr_o,
	output logic pmem_rd_o,
	input wire logic [PMEM_DW-1:0] pmem_data_i,
	output logic [7:0] tbl_low_o,
	output logic [7:0] tbl_low_addr_o,
	output logic tbl_low_vld_o,
	output logic tbl_busy_o
);
	typedef struct packed {
		csf_tb_e tb_state;
		logic [7:0] flags;
		logic [7:0] table_pointer_low;
		logic [7:0] table_pointer_high;
		logic [7:0] table_result_high;
		logic [7:0] result;
		logic result_vld;
		logic [7:0] rdata;
		logic [PMEM_DW-1:0] pmem_addr;
		logic pmem_rd;
		logic [7:0] tbl_dst;
		logic [7:0] tbl_low;
		logic tbl_low_vld;
		logic tbl_busy;
	} csf_state_s;

	csf_state_s st_r;
	csf_state_s st_nxt;
	csf_alu_if alu ();
	logic is_arith;
	logic is_logic;
	logic is_rot;
	logic has_res;
	logic new_zero;
	logic new_range;

	csf_flag_calc u_calc (
		.alu(alu.calc)
	);

	// Operands go straight to the calculator; carry in is the stored carry
	assign alu.op = instr_op_i;
	assign alu.a = op_a_i;
	assign alu.b = op_b_i;
	assign alu.cin = st_r.flags[BIT_CARRY];

	// Operation classes
	always_comb begin
		is_arith = instr_vld_i && (instr_op_i inside {OP_ADD, OP_ADC, OP_SUB, OP_SUBB});
		is_logic = instr_vld_i && (instr_op_i inside {OP_AND, OP_OR, OP_XOR});
		is_rot = instr_vld_i && (instr_op_i inside {OP_RLC, OP_RRC});
		has_res = is_arith || is_logic || is_rot;
		new_zero = (alu.res == 8'h00);
		new_range = is_arith ? (alu.msb_cin ^ alu.cout) : st_r.flags[BIT_SIGNED_RANGE];
	end

	// Next state of the whole block
	always_comb begin
		st_nxt = st_r;
		st_nxt.result_vld = 1'b0;
		st_nxt.pmem_rd = 1'b0;
		st_nxt.tbl_low_vld = 1'b0;
		st_nxt.rdata = 8'h00;
		// Read data stand for one cycle only, unmapped reads give zero
		if (rd_i) begin
			case (addr_i)
				OFF_FLAGS: st_nxt.rdata = st_r.flags;
				OFF_TPTR_LOW: st_nxt.rdata = st_r.table_pointer_low;
				OFF_TPTR_HIGH: st_nxt.rdata = st_r.table_pointer_high;
				OFF_TRES_HIGH: st_nxt.rdata = st_r.table_result_high;
				default: st_nxt.rdata = 8'h00;
			endcase
		end
		// Software writes; only the low four flag bits take data
		if (wr_i) begin
			case (addr_i)
				OFF_FLAGS: st_nxt.flags = (st_r.flags & ~FLAGS_WR_MASK)
					| (wdata_i & FLAGS_WR_MASK);
				OFF_TPTR_LOW: st_nxt.table_pointer_low = wdata_i;
				OFF_TPTR_HIGH: st_nxt.table_pointer_high = wdata_i;
				OFF_TRES_HIGH: st_nxt.table_result_high = wdata_i;
				default: st_nxt.table_result_high = st_nxt.table_result_high;
			endcase
		end
		// Arithmetic flags from the current operation win over a write
		if (is_arith) begin
			st_nxt.flags[BIT_CARRY] = alu.cout;
			st_nxt.flags[BIT_NIBBLE_WRAP] = alu.nib_cout;
			st_nxt.flags[BIT_SIGNED_RANGE] = new_range;
		end
		if (is_rot) begin
			st_nxt.flags[BIT_CARRY] = alu.cout;
		end
		if (is_arith || is_logic) begin
			st_nxt.flags[BIT_ZERO] = new_zero;
		end
		if (has_res) begin
			st_nxt.flags[BIT_XOR_SIGN] = new_range ^ alu.res[7];
			st_nxt.result = alu.res;
			st_nxt.result_vld = 1'b1;
		end
		// Chained zero moves only for the two subtract families
		if (instr_vld_i && instr_op_i == OP_SUB) begin
			st_nxt.flags[BIT_CHAINED_ZERO] = new_zero;
		end else if (instr_vld_i && instr_op_i == OP_SUBB) begin
			st_nxt.flags[BIT_CHAINED_ZERO] = st_r.flags[BIT_CHAINED_ZERO] & new_zero;
		end
		// Power management bits; watchdog expiry wins over a same-cycle clear
		if (instr_vld_i && instr_op_i == OP_SLEEP) begin
			st_nxt.flags[BIT_HALT_ENTERED] = 1'b1;
			st_nxt.flags[BIT_WDOG_EXPIRED] = 1'b0;
		end else if (instr_vld_i && instr_op_i == OP_KICK) begin
			st_nxt.flags[BIT_HALT_ENTERED] = 1'b0;
			st_nxt.flags[BIT_WDOG_EXPIRED] = 1'b0;
		end
		if (wdt_expire_i) begin
			st_nxt.flags[BIT_WDOG_EXPIRED] = 1'b1;
		end
		// Table read sequencer: issue, wait for the word, deliver bytes
		case (st_r.tb_state)
			TB_IDLE: begin
				if (instr_vld_i && instr_op_i == OP_TBLRD) begin
					st_nxt.pmem_addr = {st_r.table_pointer_high,
						st_r.table_pointer_low};
					st_nxt.pmem_rd = 1'b1;
					st_nxt.tbl_dst = tbl_dst_i;
					st_nxt.tb_state = TB_FETCH;
				end
			end
			TB_FETCH: begin
				st_nxt.tb_state = TB_DONE;
			end
			TB_DONE: begin
				st_nxt.table_result_high = pmem_data_i[15:8];
				st_nxt.tbl_low = pmem_data_i[7:0];
				st_nxt.tbl_low_vld = 1'b1;
				st_nxt.tb_state = TB_IDLE;
			end
			default: st_nxt.tb_state = TB_IDLE;
		endcase
		// Busy flag registered so that the output comes from a flip-flop
		st_nxt.tbl_busy = (st_nxt.tb_state != TB_IDLE);
	end

	// State register; flags are not pushed anywhere on calls or interrupts
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign rdata_o = st_r.rdata;
	assign flags_o = st_r.flags;
	assign result_o = st_r.result;
	assign result_vld_o = st_r.result_vld;
	assign pmem_addr_o = st_r.pmem_addr;
	assign pmem_rd_o = st_r.pmem_rd;
	assign tbl_low_o = st_r.tbl_low;
	assign tbl_low_addr_o = st_r.tbl_dst;
	assign tbl_low_vld_o = st_r.tbl_low_vld;
	assign tbl_busy_o = st_r.tbl_busy;

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	logic table_result_high_ok;
	logic [7:0] pdata_hi_q;
	property p_tbl_high;
		(st_r.tb_state == TB_DONE) |=> table_result_high_ok;
	endproperty
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pdata_hi_q <= 8'h00;
		end else begin
			pdata_hi_q <= pmem_data_i[15:8];
		end
	end
	assign table_result_high_ok = (st_r.table_result_high == pdata_hi_q) && tbl_low_vld_o;
	a_tbl_high: assert property (p_tbl_high) else $error("table high byte not captured");

	property p_flags_read;
		(rd_i && addr_i == OFF_FLAGS) |=> (rdata_o == $past(flags_o));
	endproperty
	a_flags_read: assert property (p_flags_read) else $error("flags read mismatch");

	property p_sw_locked;
		(wr_i && addr_i == OFF_FLAGS && !instr_vld_i && !wdt_expire_i)
			|=> $stable(flags_o[7:4]);
	endproperty
	a_sw_locked: assert property (p_sw_locked) else $error("write changed read-only flag");

	property p_add_carry;
		(instr_vld_i && instr_op_i == OP_ADD)
			|=> flags_o[BIT_CARRY] == ($past({1'b0, op_a_i}) + $past({1'b0, op_b_i}) > 9'h0ff);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

	property p_sub_nibble;
		(instr_vld_i && instr_op_i == OP_SUB)
			|=> flags_o[BIT_NIBBLE_WRAP] == ($past(op_a_i[3:0]) >= $past(op_b_i[3:0]));
	endproperty
	a_sub_nibble: assert property (p_sub_nibble) else $error("nibble flag wrong");

	property p_zero;
		(instr_vld_i && (instr_op_i inside {OP_AND, OP_OR, OP_XOR, OP_ADD}))
			|=> result_vld_o && (flags_o[BIT_ZERO] == (result_o == 8'h00));
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_add_range;
		(instr_vld_i && instr_op_i == OP_ADD)
			|=> flags_o[BIT_SIGNED_RANGE] == (($past(op_a_i[7]) == $past(op_b_i[7]))
				&& (result_o[7] != $past(op_a_i[7])));
	endproperty
	a_add_range: assert property (p_add_range) else $error("signed range flag wrong");

	property p_xsign;
		result_vld_o |-> flags_o[BIT_XOR_SIGN] == (flags_o[BIT_SIGNED_RANGE] ^ result_o[7]);
	endproperty
	a_xsign: assert property (p_xsign) else $error("xor-sign flag wrong");

	property p_sub_chain;
		(instr_vld_i && instr_op_i == OP_SUB)
			|=> flags_o[BIT_CHAINED_ZERO] == flags_o[BIT_ZERO];
	endproperty
	a_sub_chain: assert property (p_sub_chain) else $error("chained zero after subtract");

	property p_subb_chain;
		(instr_vld_i && instr_op_i == OP_SUBB)
			|=> flags_o[BIT_CHAINED_ZERO] == ($past(flags_o[BIT_CHAINED_ZERO]) && flags_o[BIT_ZERO]);
	endproperty
	a_subb_chain: assert property (p_subb_chain) else $error("chained zero after borrow subtract");

	property p_chain_hold;
		!(instr_vld_i && (instr_op_i inside {OP_SUB, OP_SUBB})) |=> $stable(flags_o[BIT_CHAINED_ZERO]);
	endproperty
	a_chain_hold: assert property (p_chain_hold) else $error("chained zero moved");

	property p_sleep;
		(instr_vld_i && instr_op_i == OP_SLEEP && !wdt_expire_i)
			|=> flags_o[BIT_HALT_ENTERED] && !flags_o[BIT_WDOG_EXPIRED];
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

	property p_expire;
		wdt_expire_i |=> flags_o[BIT_WDOG_EXPIRED] [*1];
	endproperty
	a_expire: assert property (p_expire) else $error("watchdog expiry lost");

	property p_tbl_addr;
		(st_r.tb_state == TB_IDLE && instr_vld_i && instr_op_i == OP_TBLRD)
			|=> pmem_rd_o && pmem_addr_o == $past({st_r.table_pointer_high,
				st_r.table_pointer_low}) ##2 tbl_low_vld_o;
	endproperty
	a_tbl_addr: assert property (p_tbl_addr) else $error("table fetch address wrong");
endmodule

/* rtl/csf_flag_calc.sv */
// Result and carry calculator for arithmetic, logic and rotate operations
`timescale 1ns/1ps
module csf_flag_calc
	import csf_pkg::*;
(
	csf_alu_if.calc alu
);
	logic [7:0] bb;
	logic ci;
	logic sub;
	logic [8:0] sum9;
	logic [4:0] lo5;
	logic [7:0] lo8;

	// Subtraction adds the inverted operand, carry in means no borrow
	always_comb begin
		sub = (alu.op == OP_SUB) || (alu.op == OP_SUBB);
		bb = sub ? ~alu.b : alu.b;
		case (alu.op)
			OP_ADD: ci = 1'b0;
			OP_SUB: ci = 1'b1;
			default: ci = alu.cin;
		endcase
		sum9 = {1'b0, alu.a} + {1'b0, bb} + {8'h00, ci};
		lo5 = {1'b0, alu.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		lo8 = {1'b0, alu.a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
		alu.nib_cout = lo5[4];
		alu.msb_cin = lo8[7];
		case (alu.op)
			OP_AND: begin
				alu.res = alu.a & alu.b;
				alu.cout = 1'b0;
			end
			OP_OR: begin
				alu.res = alu.a | alu.b;
				alu.cout = 1'b0;
			end
			OP_XOR: begin
				alu.res = alu.a ^ alu.b;
				alu.cout = 1'b0;
			end
			OP_RLC: begin
				alu.res = {alu.a[6:0], alu.cin};
				alu.cout = alu.a[7];
			end
			OP_RRC: begin
				alu.res = {alu.cin, alu.a[7:1]};
				alu.cout = alu.a[0];
			end
			default: begin
				alu.res = sum9[7:0];
				alu.cout = sum9[8];
			end
		endcase
	end
endmodule

/* rtl/csf_pkg.sv */
// Shared constants and types for the status flag and table pointer block
package csf_pkg;
	// Register bus geometry and register indexes
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_TPTR_LOW = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_TPTR_HIGH = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_TRES_HIGH = 4'h3;
	// Flag bit positions
	localparam int BIT_CARRY = 0;
	localparam int BIT_NIBBLE_WRAP = 1;
	localparam int BIT_ZERO = 2;
	localparam int BIT_SIGNED_RANGE = 3;
	localparam int BIT_HALT_ENTERED = 4;
	localparam int BIT_WDOG_EXPIRED = 5;
	localparam int BIT_CHAINED_ZERO = 6;
	localparam int BIT_XOR_SIGN = 7;
	// Values after reset and writable mask
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] FLAGS_WR_MASK = 8'h0f;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam int PMEM_DW = 16;
	// Operations issued by the execution logic
	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_ADD = 4'h1, OP_ADC = 4'h2, OP_SUB = 4'h3,
		OP_SUBB = 4'h4, OP_AND = 4'h5, OP_OR = 4'h6, OP_XOR = 4'h7,
		OP_RLC = 4'h8, OP_RRC = 4'h9, OP_SLEEP = 4'ha, OP_KICK = 4'hb,
		OP_TBLRD = 4'hc
	} csf_op_e;
	// Table read sequencer
	typedef enum logic [1:0] {
		TB_IDLE = 2'b00, TB_FETCH = 2'b01, TB_DONE = 2'b11
	} csf_tb_e;
endpackage

/* verif/csf_pmem_model.sv */
// Program memory model that answers table reads of the flag block
`timescale 1ns/1ps
module csf_pmem_model
	import csf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic pmem_rd_i,
	input wire logic [PMEM_DW-1:0] pmem_addr_i,
	output logic [PMEM_DW-1:0] pmem_data_o
);
	// Word content is a fixed scramble of its address
	localparam logic [PMEM_DW-1:0] SCRAMBLE = 16'hc35a;

	// Word stands for one cycle after the read pulse; otherwise the bus toggles
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pmem_data_o <= 16'h0000;
		end else if (pmem_rd_i) begin
			pmem_data_o <= pmem_addr_i ^ SCRAMBLE;
		end else begin
			pmem_data_o <= ~pmem_data_o; // Stale data never looks valid
		end
	end
endmodule

/* verif/testbench.sv */
// Self-checking bench for the status flag and table pointer block
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench
	import csf_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [ADDR_W-1:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic instr_vld_i = 1'b0;
	csf_op_e instr_op_i = OP_NOP;
	logic [7:0] op_a_i = 8'h00;
	logic [7:0] op_b_i = 8'h00;
	logic [7:0] tbl_dst_i = 8'h00;
	logic wdt_expire_i = 1'b0;
	logic [7:0] rdata_o, flags_o, result_o, tbl_low_o, tbl_low_addr_o;
	logic result_vld_o, pmem_rd_o, tbl_low_vld_o, tbl_busy_o;
	logic [PMEM_DW-1:0] pmem_addr_o, pmem_data_i;
	int errors = 0;
	int n_checks = 0;
	logic [7:0] ef;
	logic [15:0] m;
	csf_op_e ops[15] = '{OP_ADD, OP_ADC, OP_SUB, OP_SUBB, OP_SUBB, OP_SUBB, OP_SUB, OP_ADD,
		OP_AND, OP_OR, OP_XOR, OP_RLC, OP_RRC, OP_ADC, OP_NOP};
	logic [7:0] va[15] = '{8'hff, 8'h7f, 8'h05, 8'h03, 8'h03, 8'h00, 8'h10, 8'h00,
		8'hf0, 8'h80, 8'h55, 8'h81, 8'h01, 8'h0f, 8'h00};
	logic [7:0] vb[15] = '{8'h01, 8'h00, 8'h05, 8'h03, 8'h01, 8'h00, 8'h20, 8'h00,
		8'h0f, 8'h00, 8'h55, 8'h00, 8'h00, 8'h01, 8'h00};

	// System clock, 100 MHz
	always #5 clk_i = ~clk_i;

	csf_core u_csf_core (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .instr_vld_i(instr_vld_i),
		.instr_op_i(instr_op_i), .op_a_i(op_a_i), .op_b_i(op_b_i), .tbl_dst_i(tbl_dst_i),
		.wdt_expire_i(wdt_expire_i), .flags_o(flags_o), .result_o(result_o),
		.result_vld_o(result_vld_o), .pmem_addr_o(pmem_addr_o), .pmem_rd_o(pmem_rd_o),
		.pmem_data_i(pmem_data_i), .tbl_low_o(tbl_low_o), .tbl_low_addr_o(tbl_low_addr_o),
		.tbl_low_vld_o(tbl_low_vld_o), .tbl_busy_o(tbl_busy_o));

	csf_pmem_model u_csf_pmem_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .pmem_rd_i(pmem_rd_o),
		.pmem_addr_i(pmem_addr_o), .pmem_data_o(pmem_data_i));

	// Expected flags and result of one operation, worked out from the flag definitions
	function automatic logic [15:0] model(csf_op_e op, logic [7:0] a, logic [7:0] b,
		logic [7:0] f);
		logic [8:0] s;
		logic [4:0] n;
		logic [7:0] c7;
		logic [7:0] r;
		logic [7:0] nf;
		logic [7:0] bb;
		logic ci;
		nf = f;
		r = 8'h00;
		bb = (op == OP_SUB || op == OP_SUBB) ? ~b : b;
		ci = (op == OP_ADD) ? 1'b0 : ((op == OP_SUB) ? 1'b1 : f[0]);
		s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
		n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		c7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
		case (op)
			OP_ADD, OP_ADC, OP_SUB, OP_SUBB: begin
				r = s[7:0];
				nf[0] = s[8];
				nf[1] = n[4];
				nf[3] = c7[7] ^ s[8];
			end
			OP_AND: r = a & b;
			OP_OR: r = a | b;
			OP_XOR: r = a ^ b;
			OP_RLC: begin
				r = {a[6:0], f[0]};
				nf[0] = a[7];
			end
			OP_RRC: begin
				r = {f[0], a[7:1]};
				nf[0] = a[0];
			end
			OP_SLEEP: nf[5:4] = 2'b01;
			OP_KICK: nf[5:4] = 2'b00;
			default: nf = f;
		endcase
		if (op inside {OP_ADD, OP_ADC, OP_SUB, OP_SUBB, OP_AND, OP_OR, OP_XOR}) begin
			nf[2] = (r == 8'h00);
		end
		if (op == OP_SUB) begin
			nf[6] = nf[2];
		end
		if (op == OP_SUBB) begin
			nf[6] = f[6] & nf[2];
		end
		if (op inside {OP_ADD, OP_ADC, OP_SUB, OP_SUBB, OP_AND, OP_OR, OP_XOR, OP_RLC, OP_RRC}) begin
			nf[7] = nf[3] ^ r[7];
		end
		return {nf, r};
	endfunction

	// Closing report
	task automatic print_verdict();
		if (errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One register write cycle
	task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// One register read cycle; data checked in the following cycle only
	task automatic bus_rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		`CHK(rdata_o, e)
	endtask

	// One operation, optionally with a watchdog expiry in the same cycle
	task automatic do_op(input csf_op_e op, input logic [7:0] a, input logic [7:0] b,
		input logic wdt);
		@(posedge clk_i);
		instr_vld_i <= 1'b1;
		instr_op_i <= op;
		op_a_i <= a;
		op_b_i <= b;
		wdt_expire_i <= wdt;
		@(posedge clk_i);
		instr_vld_i <= 1'b0;
		wdt_expire_i <= 1'b0;
		#1;
	endtask

	// Bounded wait for a pulse: 0 read strobe, 1 low byte valid
	task automatic wait_for(input int sel);
		int k;
		k = 0;
		while (((sel == 0) ? pmem_rd_o : tbl_low_vld_o) !== 1'b1 && k < 20) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		if (k == 20) begin
			errors++;
			print_verdict();
		end
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		#1;
		`CHK(flags_o, 8'h00)
		bus_rd(OFF_FLAGS, 8'h00);
		bus_wr(OFF_FLAGS, 8'hff);
		bus_rd(OFF_FLAGS, 8'h0f);
		bus_rd(4'hf, 8'h00);
		ef = 8'h0f;
		// Back-to-back arithmetic, logic and rotate operations
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_i);
			instr_vld_i <= (i < 15);
			instr_op_i <= ops[i % 15];
			op_a_i <= va[i % 15];
			op_b_i <= vb[i % 15];
			if (i > 0) begin
				#1;
				m = model(ops[i - 1], va[i - 1], vb[i - 1], ef);
				ef = m[15:8];
				`CHK(flags_o, ef)
				if (ops[i - 1] != OP_NOP) begin
					`CHK({result_vld_o, result_o}, {1'b1, m[7:0]})
				end
			end
		end
		bus_rd(OFF_FLAGS, ef);
		// Halt and watchdog flags
		do_op(OP_SLEEP, 8'h00, 8'h00, 1'b0);
		ef[5:4] = 2'b01;
		`CHK(flags_o, ef)
		do_op(OP_NOP, 8'h00, 8'h00, 1'b1);
		ef[5] = 1'b1;
		`CHK(flags_o, ef)
		bus_wr(OFF_FLAGS, 8'h00);
		#1;
		ef[3:0] = 4'h0;
		`CHK(flags_o, ef)
		do_op(OP_KICK, 8'h00, 8'h00, 1'b0);
		ef[5:4] = 2'b00;
		`CHK(flags_o, ef)
		do_op(OP_SLEEP, 8'h00, 8'h00, 1'b1);
		ef[5:4] = 2'b11;
		`CHK(flags_o, ef)
		// Table read through the pointer pair
		bus_wr(OFF_TPTR_LOW, 8'h34);
		bus_wr(OFF_TPTR_HIGH, 8'h12);
		tbl_dst_i <= 8'h5a;
		do_op(OP_TBLRD, 8'h00, 8'h00, 1'b0);
		wait_for(0);
		`CHK(pmem_addr_o, 16'h1234)
		`CHK(tbl_busy_o, 1'b1)
		wait_for(1);
		`CHK({tbl_low_o, tbl_low_addr_o}, 16'h6e5a)
		`CHK(tbl_busy_o, 1'b0)
		`CHK(flags_o, ef)
		bus_rd(OFF_TRES_HIGH, 8'hd1);
		bus_rd(OFF_TPTR_HIGH, 8'h12);
		print_verdict();
	end
endmodule
